// >>> core/rbr_pkg.sv
package rbr_pkg;

	// ----------------------------------------------------------------
	// Register map, Avalon word addresses (byte address / 4).
	// ----------------------------------------------------------------
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h1;
	localparam logic [3:0] ADDR_HWVER = 4'h2;
	localparam logic [3:0] ADDR_FWVER = 4'h3;
	localparam logic [3:0] ADDR_STORE_BAUD = 4'h4;
	localparam logic [3:0] ADDR_STORE_MSGSET = 4'h5;
	localparam logic [3:0] ADDR_STORE_FREQ = 4'h6;
	localparam logic [3:0] ADDR_SOFT_RESET = 4'h7;

	// ----------------------------------------------------------------
	// Field positions.
	// ----------------------------------------------------------------
	localparam int STAT_BOOT_ROM = 0;
	localparam int STAT_EXT_REF = 1;
	localparam int STAT_PPS_EXT = 2;
	localparam int STAT_HOLDOVER = 3;
	localparam int STAT_IN_RESET = 4;
	localparam int CTRL_HOLDOVER_SW = 0;

	// ----------------------------------------------------------------
	// Reset values and identity (identity values are arbitrary).
	// ----------------------------------------------------------------
	localparam logic [31:0] HW_VERSION = 32'h0000_0101;
	localparam logic [31:0] FW_VERSION = 32'h0000_0201;
	localparam logic [31:0] STORE_BAUD_RST = 32'h0000_9600;
	localparam logic [31:0] STORE_MSGSET_RST = 32'h0000_00ff;
	localparam logic [31:0] STORE_FREQ_RST = 32'h0098_9680;
	localparam logic [31:0] SOFT_RESET_KEY = 32'h0000_00a5;

	// ----------------------------------------------------------------
	// Timing.
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 5000;
	localparam int HARD_RESET_MIN_NS = 1000;
	localparam int HARD_RESET_CYCLES = (HARD_RESET_MIN_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int RST_CNT_W = 8;
	localparam logic [RST_CNT_W-1:0] HARD_RESET_CNT = RST_CNT_W'(HARD_RESET_CYCLES);
	localparam int SYNC_W = 5;

	// ----------------------------------------------------------------
	// Sequencer states.
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SEQ_RESET = 2'b00,
		SEQ_LOW = 2'b01,
		SEQ_RUN = 2'b10
	} rbr_seq_t;

endpackage

// >>> core/rbr_sync.sv
`timescale 1ns/1ps

// Two-stage synchroniser, one per input bit.
module rbr_sync (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [rbr_pkg::SYNC_W-1:0] asyncIn,
	output logic [rbr_pkg::SYNC_W-1:0] syncOut
);

	logic [rbr_pkg::SYNC_W-1:0] stage1_r;

	// ----------------------------------------------------------------
	// Synchroniser chain.
	// ----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < rbr_pkg::SYNC_W; i++) begin : g_bit
			// First stage feeds only the second stage; both preset high to match pull-ups.
			always_ff @(posedge clk) begin
				if (!rst_b) begin
					stage1_r[i] <= 1'b1;
					syncOut[i] <= 1'b1;
				end else begin
					stage1_r[i] <= asyncIn[i];
					syncOut[i] <= stage1_r[i];
				end
			end
		end
	endgenerate

endmodule

// >>> core/rbr_core.sv
`timescale 1ns/1ps

// Notes on behaviour
// - Boot from flash when boot select high or open, from ROM when low.
// - Hard reset pin low for at least 1 us then released gives full reset.
// - Reference choice high picks internal oscillator, low picks external 10 MHz.
// - Reference choice is latched and only changes after a full reset.
// - Pulse choice pin selects external pulse instead of receiver pulse.
// - Holdover request forces holdover, ignoring the pulse reference.
// - User settings are held in storage that survives hard and soft resets; rst_b (power-on) loads defaults.
// - Fixed hardware and firmware version numbers are readable.
module rbr_core (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic bootSourceSelect,
	input wire logic hardResetPin_b,
	input wire logic extRefChoose_b,
	input wire logic ppsRefChoose_b,
	input wire logic holdoverForce,
	input wire logic [3:0] avsAddress,
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic [31:0] avsWriteData,
	input wire logic [3:0] avsByteEnable,
	output logic [31:0] avsReadData,
	output logic avsWaitRequest,
	output logic moduleReset,
	output logic bootFromRom,
	output logic useExtRef,
	output logic usePpsExt,
	output logic inHoldover,
	output logic [31:0] storeBaud,
	output logic [31:0] storeMsgSet,
	output logic [31:0] storeFreq
);

	logic [rbr_pkg::SYNC_W-1:0] syncIn;
	logic bootS;
	logic hardRstS_b;
	logic extRefS_b;
	logic ppsS_b;
	logic holdS;
	rbr_pkg::rbr_seq_t seq_r;
	logic [rbr_pkg::RST_CNT_W-1:0] lowCnt_r;
	logic [1:0] settle_r;
	logic strapTake;
	logic swReset_r;
	logic holdSw_r;
	logic ack_r;
	logic [31:0] storeBaud_nxt;
	logic [31:0] storeMsgSet_nxt;
	logic [31:0] storeFreq_nxt;
	logic wrHit;

	// ----------------------------------------------------------------
	// Input synchronisers.
	// ----------------------------------------------------------------
	rbr_sync uSync (
		.clk(clk),
		.rst_b(rst_b),
		.asyncIn({holdoverForce, ppsRefChoose_b, extRefChoose_b, hardResetPin_b,
			bootSourceSelect}),
		.syncOut(syncIn)
	);

	// Named views of the synchronised pins.
	assign bootS = syncIn[0];
	assign hardRstS_b = syncIn[1];
	assign extRefS_b = syncIn[2];
	assign ppsS_b = syncIn[3];
	assign holdS = syncIn[4];

	// ----------------------------------------------------------------
	// Hard reset sequencer.
	// ----------------------------------------------------------------
	// The synchronisers start preset high, so after power-on the straps are trusted only
	// once real pin levels have passed both stages.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			settle_r <= 2'b00;
		end else begin
			settle_r <= {settle_r[0], 1'b1};
		end
	end

	// Low pulses shorter than the minimum are ignored; release after a long pulse starts the reset.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			seq_r <= rbr_pkg::SEQ_RESET;
			lowCnt_r <= '0;
		end else begin
			unique case (seq_r)
				rbr_pkg::SEQ_RESET: begin
					lowCnt_r <= '0;
					if (settle_r[1]) begin
						seq_r <= rbr_pkg::SEQ_RUN;
					end
				end
				rbr_pkg::SEQ_RUN: begin
					lowCnt_r <= '0;
					if (!hardRstS_b) begin
						seq_r <= rbr_pkg::SEQ_LOW;
					end else if (swReset_r) begin
						seq_r <= rbr_pkg::SEQ_RESET;
					end
				end
				rbr_pkg::SEQ_LOW: begin
					if (hardRstS_b) begin
						seq_r <= (lowCnt_r >= rbr_pkg::HARD_RESET_CNT - 8'h01) ?
							rbr_pkg::SEQ_RESET : rbr_pkg::SEQ_RUN;
						lowCnt_r <= '0;
					end else if (lowCnt_r != 8'hff) begin
						lowCnt_r <= lowCnt_r + 8'h01;
					end
				end
				default: begin
					seq_r <= rbr_pkg::SEQ_RESET;
				end
			endcase
		end
	end

	// Module reset is high during the reset state.
	assign moduleReset = (seq_r == rbr_pkg::SEQ_RESET);
	assign strapTake = (seq_r == rbr_pkg::SEQ_RESET);

	// ----------------------------------------------------------------
	// Strap capture.
	// ----------------------------------------------------------------
	// Straps are taken only in the reset state and then held while running.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			bootFromRom <= 1'b0;
			useExtRef <= 1'b0;
		end else if (strapTake) begin
			bootFromRom <= !bootS;
			useExtRef <= !extRefS_b;
		end
	end

	// ----------------------------------------------------------------
	// Live reference and holdover controls.
	// ----------------------------------------------------------------
	// Pulse reference choice follows the pin; holdover by pin or software.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			usePpsExt <= 1'b0;
			inHoldover <= 1'b0;
		end else begin
			usePpsExt <= !ppsS_b && !moduleReset;
			inHoldover <= (holdS || holdSw_r) && !moduleReset;
		end
	end

	// ----------------------------------------------------------------
	// Avalon slave: one wait state, answer on the second cycle.
	// ----------------------------------------------------------------
	// Acknowledge pulses one cycle after a request appears.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= (avsRead || avsWrite) && !ack_r;
		end
	end

	assign avsWaitRequest = (avsRead || avsWrite) && !ack_r;
	assign wrHit = avsWrite && ack_r;

	// Read data register, zero for unmapped words.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			avsReadData <= 32'h0000_0000;
		end else if (avsRead && !ack_r) begin
			unique case (avsAddress)
				rbr_pkg::ADDR_CTRL: avsReadData <= {31'h0, holdSw_r};
				rbr_pkg::ADDR_STATUS: avsReadData <= {27'h0, moduleReset, inHoldover,
					usePpsExt, useExtRef, bootFromRom};
				rbr_pkg::ADDR_HWVER: avsReadData <= rbr_pkg::HW_VERSION;
				rbr_pkg::ADDR_FWVER: avsReadData <= rbr_pkg::FW_VERSION;
				rbr_pkg::ADDR_STORE_BAUD: avsReadData <= storeBaud;
				rbr_pkg::ADDR_STORE_MSGSET: avsReadData <= storeMsgSet;
				rbr_pkg::ADDR_STORE_FREQ: avsReadData <= storeFreq;
				default: avsReadData <= 32'h0000_0000;
			endcase
		end
	end

	// Software holdover bit and soft reset pulse.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			holdSw_r <= 1'b0;
			swReset_r <= 1'b0;
		end else begin
			swReset_r <= wrHit && (avsAddress == rbr_pkg::ADDR_SOFT_RESET) &&
				avsByteEnable[0] && (avsWriteData[7:0] == rbr_pkg::SOFT_RESET_KEY[7:0]);
			if (wrHit && (avsAddress == rbr_pkg::ADDR_CTRL) && avsByteEnable[0]) begin
				holdSw_r <= avsWriteData[rbr_pkg::CTRL_HOLDOVER_SW];
			end
		end
	end

	// ----------------------------------------------------------------
	// Persistent storage.
	// ----------------------------------------------------------------
	// Byte-lane merge of a write into a stored word.
	function automatic logic [31:0] mergeBytes(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				res[b*8 +: 8] = data[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// Next values of the stored settings.
	always_comb begin
		storeBaud_nxt = storeBaud;
		storeMsgSet_nxt = storeMsgSet;
		storeFreq_nxt = storeFreq;
		if (wrHit && avsAddress == rbr_pkg::ADDR_STORE_BAUD) begin
			storeBaud_nxt = mergeBytes(storeBaud, avsWriteData, avsByteEnable);
		end
		if (wrHit && avsAddress == rbr_pkg::ADDR_STORE_MSGSET) begin
			storeMsgSet_nxt = mergeBytes(storeMsgSet, avsWriteData, avsByteEnable);
		end
		if (wrHit && avsAddress == rbr_pkg::ADDR_STORE_FREQ) begin
			storeFreq_nxt = mergeBytes(storeFreq, avsWriteData, avsByteEnable);
		end
	end

	// Settings survive hard and soft resets; only rst_b (power-on) loads defaults.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			storeBaud <= rbr_pkg::STORE_BAUD_RST;
			storeMsgSet <= rbr_pkg::STORE_MSGSET_RST;
			storeFreq <= rbr_pkg::STORE_FREQ_RST;
		end else begin
			storeBaud <= storeBaud_nxt;
			storeMsgSet <= storeMsgSet_nxt;
			storeFreq <= storeFreq_nxt;
		end
	end

endmodule

// >>> dv/rbr_core_monitor.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port checker for rbr_core.
// ----------------------------------------
module rbr_core_monitor (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic bootSourceSelect,
	input wire logic hardResetPin_b,
	input wire logic extRefChoose_b,
	input wire logic ppsRefChoose_b,
	input wire logic holdoverForce,
	input wire logic [3:0] avsAddress,
	input wire logic avsRead,
	input wire logic [31:0] avsReadData,
	input wire logic avsWaitRequest,
	input wire logic moduleReset,
	input wire logic bootFromRom,
	input wire logic useExtRef,
	input wire logic usePpsExt,
	input wire logic inHoldover,
	input wire logic [31:0] storeBaud
);
	logic [7:0] lowRun;
	logic [3:0] runCnt;
	logic [3:0] strapCnt;
	// Counts pin low time, cycles out of reset and cycles of steady straps.
	always_ff @(posedge clk) begin
		lowRun <= hardResetPin_b ? 8'h00 : lowRun + {7'h00, lowRun != 8'hff};
		runCnt <= (!rst_b || moduleReset) ? 4'h0 : runCnt + {3'h0, runCnt != 4'hf};
		strapCnt <= (!rst_b || !$stable(bootSourceSelect) || !$stable(extRefChoose_b)) ? 4'h0
			: strapCnt + {3'h0, strapCnt != 4'hf};
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	a_boot_latch: assert property (
		$fell(moduleReset) && strapCnt > 4'h5 |-> bootFromRom == !bootSourceSelect)
		else $error("boot source not taken from strap");
	a_ref_latch: assert property (
		$fell(moduleReset) && strapCnt > 4'h5 |-> useExtRef == !extRefChoose_b)
		else $error("reference choice not taken from strap");
	a_ref_held: assert property (
		!moduleReset && !$past(moduleReset) |-> $stable(useExtRef) && $stable(bootFromRom))
		else $error("strap outputs changed while running");
	a_pps_follow: assert property (
		runCnt > 4'h4 |-> usePpsExt == !$past(ppsRefChoose_b, 3))
		else $error("pulse choice not followed");
	a_hold_force: assert property (
		runCnt > 4'h4 && $past(holdoverForce, 3) |-> inHoldover)
		else $error("holdover request ignored");
	a_reset_long: assert property (
		$rose(hardResetPin_b) && lowRun > 8'hcc |-> ##[1:6] moduleReset)
		else $error("long reset pulse gave no reset");
	a_reset_short: assert property (
		$rose(hardResetPin_b) && lowRun < 8'hc3 |-> !moduleReset [*8])
		else $error("short reset pulse gave a reset");
	a_reset_pulse: assert property (
		$rose(moduleReset) |=> !moduleReset)
		else $error("reset pulse longer than one cycle");
	a_bus_wait: assert property (
		$rose(avsRead) |-> avsWaitRequest ##1 !avsWaitRequest)
		else $error("read answer not one cycle late");
	a_hwver_read: assert property (
		avsRead && !avsWaitRequest && avsAddress == rbr_pkg::ADDR_HWVER
		|-> avsReadData == rbr_pkg::HW_VERSION)
		else $error("hardware version wrong");
	a_store_keep: assert property (
		moduleReset |=> $stable(storeBaud))
		else $error("stored setting lost in reset");
	c_hard: cover property ($rose(moduleReset));
	c_hold: cover property (inHoldover && runCnt > 4'h4);
	c_rom: cover property (bootFromRom && useExtRef);
endmodule

bind rbr_core rbr_core_monitor u_mon (.clk(clk), .rst_b(rst_b),
	.bootSourceSelect(bootSourceSelect), .hardResetPin_b(hardResetPin_b),
	.extRefChoose_b(extRefChoose_b), .ppsRefChoose_b(ppsRefChoose_b),
	.holdoverForce(holdoverForce), .avsAddress(avsAddress), .avsRead(avsRead),
	.avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .moduleReset(moduleReset),
	.bootFromRom(bootFromRom), .useExtRef(useExtRef), .usePpsExt(usePpsExt),
	.inHoldover(inHoldover), .storeBaud(storeBaud));

// >>> dv/rbr_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Host board driving the hard reset pin.
// ----------------------------------------
module rbr_host_model (
	input wire logic clk,
	input wire logic pulseGo,
	input wire logic [8:0] pulseLen,
	output logic hardResetPin_b
);
	logic [8:0] lowLeft_r = 9'h000;
	// Holds the pin low for pulseLen cycles; the pull-up wins otherwise.
	always_ff @(posedge clk) begin
		if (pulseGo) begin
			lowLeft_r <= pulseLen;
		end else if (lowLeft_r != 9'h000) begin
			lowLeft_r <= lowLeft_r - 9'h001;
		end
	end
	assign hardResetPin_b = (lowLeft_r == 9'h000);
endmodule

// >>> dv/reset_boot_refsel_control_tb_top.sv
`timescale 1ns/1ps
// ----------------------------------------
// Bench for the control front end.
// ----------------------------------------
module reset_boot_refsel_control_tb_top;
	logic clk = 1'b0, rst_b = 1'b0, boot = 1'b1, ext_b = 1'b1, pps_b = 1'b1, hold = 1'b0;
	logic avsRead = 1'b0, avsWrite = 1'b0, pulseGo = 1'b0, hrst_b, avsWait, modRst;
	logic rom, ext, ppsExt, inHold;
	logic [3:0] avsAddr = 4'h0, avsBe = 4'h0, be;
	logic [31:0] avsWd = 32'h0, avsRd, rd, wd, sBaud;
	logic [31:0] st [4:6];
	logic [8:0] pulseLen = 9'h000;
	int nMismatch = 0, comparisons = 0, cyc = 0, nRst = 0, nBefore = 0;
	initial begin
		forever #2.5 clk = ~clk;
	end
	rbr_core dut (.clk(clk), .rst_b(rst_b), .bootSourceSelect(boot), .hardResetPin_b(hrst_b),
		.extRefChoose_b(ext_b), .ppsRefChoose_b(pps_b), .holdoverForce(hold),
		.avsAddress(avsAddr), .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWd),
		.avsByteEnable(avsBe), .avsReadData(avsRd), .avsWaitRequest(avsWait),
		.moduleReset(modRst), .bootFromRom(rom), .useExtRef(ext), .usePpsExt(ppsExt),
		.inHoldover(inHold), .storeBaud(sBaud), .storeMsgSet(), .storeFreq());
	rbr_host_model host (.clk(clk), .pulseGo(pulseGo), .pulseLen(pulseLen),
		.hardResetPin_b(hrst_b));
	// Counts reset pulses and cuts a hang short.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (rst_b && modRst) nRst <= nRst + 1;
		if (cyc == 6000) begin
			nMismatch++;
			final_report;
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		comparisons++;
		if (seen !== want) begin
			nMismatch++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, want);
		end
	endtask
	task final_report;
		if (nMismatch == 0 && comparisons > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// One bus access, held until waitrequest is seen low.
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] b);
		@(posedge clk);
		avsRead <= !wr;
		avsWrite <= wr;
		avsAddr <= a;
		avsWd <= d;
		avsBe <= b;
		do @(posedge clk); while (avsWait !== 1'b0);
		rd = avsRd;
		avsRead <= 1'b0;
		avsWrite <= 1'b0;
	endtask
	task automatic pulse(input logic [8:0] n, input int want);
		int n0;
		n0 = nRst;
		@(posedge clk);
		pulseLen <= n;
		pulseGo <= 1'b1;
		@(posedge clk);
		pulseGo <= 1'b0;
		repeat (n + 20) @(posedge clk);
		chk(32'(nRst - n0), 32'(want));
	endtask
	function automatic logic [31:0] dflt(input int a);
		return a == 4 ? rbr_pkg::STORE_BAUD_RST : a == 5 ? rbr_pkg::STORE_MSGSET_RST
			: rbr_pkg::STORE_FREQ_RST;
	endfunction
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] b);
		for (int i = 0; i < 4; i++) if (b[i]) o[8*i+:8] = n[8*i+:8];
		return o;
	endfunction
	// Main sequence.
	initial begin
		void'($urandom(11374));
		@(posedge clk);
		boot <= 1'($urandom);
		ext_b <= 1'($urandom);
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		bus(1'b0, rbr_pkg::ADDR_HWVER, 32'h0, 4'h0);
		chk(rd, rbr_pkg::HW_VERSION);
		bus(1'b0, rbr_pkg::ADDR_FWVER, 32'h0, 4'h0);
		chk(rd, rbr_pkg::FW_VERSION);
		chk(32'({rom, ext}), 32'({!boot, !ext_b}));
		bus(1'b0, 4'h9, 32'h0, 4'h0);
		chk(rd, 32'h0);
		for (int i = 4; i < 7; i++) begin
			bus(1'b0, 4'(i), 32'h0, 4'h0);
			chk(rd, dflt(i));
			wd = $urandom;
			be = (i == 4) ? 4'hf : 4'($urandom);
			st[i] = merge(dflt(i), wd, be);
			bus(1'b1, 4'(i), wd, be);
		end
		pulse(9'h064, 0);
		for (int k = 0; k < 4; k++) begin
			boot <= k[0];
			ext_b <= k[1];
			pulse(9'h0d2, 1);
			chk(32'({rom, ext}), 32'({!k[0], !k[1]}));
			boot <= !k[0];
			ext_b <= !k[1];
			repeat (10) @(posedge clk);
			chk(32'({rom, ext}), 32'({!k[0], !k[1]}));
		end
		// Software holdover, status view, then soft reset with a wrong and a right key.
		bus(1'b1, rbr_pkg::ADDR_CTRL, 32'h0000_0001, 4'h1);
		repeat (3) @(posedge clk);
		chk(32'(inHold), 32'h0000_0001);
		bus(1'b0, rbr_pkg::ADDR_CTRL, 32'h0, 4'h0);
		chk(rd, 32'h0000_0001);
		bus(1'b0, rbr_pkg::ADDR_STATUS, 32'h0, 4'h0);
		chk(rd, 32'h0000_0001 << rbr_pkg::STAT_HOLDOVER);
		bus(1'b1, rbr_pkg::ADDR_CTRL, 32'h0, 4'h1);
		nBefore = nRst;
		bus(1'b1, rbr_pkg::ADDR_SOFT_RESET, 32'h0000_005a, 4'h1);
		repeat (4) @(posedge clk);
		chk(32'(nRst - nBefore), 32'h0);
		bus(1'b1, rbr_pkg::ADDR_SOFT_RESET, rbr_pkg::SOFT_RESET_KEY, 4'h1);
		repeat (4) @(posedge clk);
		chk(32'(nRst - nBefore), 32'h0000_0001);
		chk(32'({rom, ext}), 32'({!boot, !ext_b}));
		for (int i = 4; i < 7; i++) begin
			bus(1'b0, 4'(i), 32'h0, 4'h0);
			chk(rd, st[i]);
		end
		chk(sBaud, st[4]);
		for (int k = 0; k < 8; k++) begin
			@(posedge clk);
			pps_b <= 1'($urandom);
			hold <= 1'($urandom);
			repeat (6) @(posedge clk);
			chk(32'({inHold, ppsExt}), 32'({hold, !pps_b}));
		end
		final_report;
	end
endmodule
